// ---- common/pbseq_pkg.sv ----
// Package: constants, states and carriers of the pushbutton power sequencer
// What this block does
// - Undervoltage in powered state enters soft down
// - Soft down drops wake, good, all regulators
// - Undervoltage cleared after delay: second powerup
// - Soft down passes through off state first
// - Five second press raises long-press event
// - Hard down disables everything, wake, good low
// - One second later hard down enters shipping
// - Held press needs release, then 400ms
// - 400ms press wakes and enables first buck
// - Second buck after first within 8%
// - Third buck after second within 8%
// - Bucks good released 230ms after third
// - Powerup lasts 5s; hold power needed then
// - Down states reset serial control registers
// - One second wait ignores button, hold, power
package pbseq_pkg;

  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned LONG_PRESS_MS = 5000;
  localparam int unsigned DOWN_MS       = 1000;
  localparam int unsigned PRESS_ON_MS   = 400;
  localparam int unsigned GOOD_MS       = 230;
  localparam int unsigned POWERUP_MS    = 5000;
  localparam int unsigned TICK_W        = 18;
  localparam int unsigned MS_W          = 13;
  localparam logic [MS_W-1:0] LONG_PRESS_TICKS = MS_W'(LONG_PRESS_MS);
  localparam logic [MS_W-1:0] DOWN_TICKS       = MS_W'(DOWN_MS);
  localparam logic [MS_W-1:0] PRESS_ON_TICKS   = MS_W'(PRESS_ON_MS);
  localparam logic [MS_W-1:0] GOOD_TICKS       = MS_W'(GOOD_MS);
  localparam logic [MS_W-1:0] POWERUP_TICKS    = MS_W'(POWERUP_MS);
  localparam logic [MS_W-1:0] MS_ZERO          = '0;

  typedef enum logic [2:0] {
    ST_SHIPPING, ST_OFF, ST_FIRST_POWERUP_STATE, ST_SECOND_POWERUP_STATE, ST_POWERED, ST_HARD_DOWN,
    ST_SOFT_DOWN
  } pbseq_state_t;

  // Sampled pins after synchronisers
  typedef struct packed {
    logic button_pressed;
    logic hold_power;
    logic undervoltage;
    logic ext_power;
    logic [2:0] buck_near;
  } pbseq_in_t;

  typedef struct packed {
    logic       wake;
    logic       good_oe_n;
    logic [2:0] buck_en;
    logic       regs_clear;
  } pbseq_out_t;

endpackage

// ---- rtl/pbseq_sync.sv ----
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pbseq_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // pbseq_sync

// ---- rtl/pbseq_top.sv ----
// Pushbutton power state machine with ordered buck enables
`timescale 1ns/1ps
module pbseq_top
  import pbseq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       button_n,
  input  wire logic       hold_power_in,
  input  wire logic       output_undervoltage,
  input  wire logic       ext_power_in,
  input  wire logic [2:0] buck_near_in,
  output logic            wake_out,
  output logic            bucks_good_out_o,
  output logic            bucks_good_out_oe,
  output logic [2:0]      buck_en_out,
  output logic            regs_clear_out,
  output logic [2:0]      state_out
);

  logic [6:0] raw_in;
  logic [6:0] sync_in;
  pbseq_in_t  pins;

  pbseq_sync #(.WIDTH(7)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign raw_in = {~button_n, hold_power_in, output_undervoltage,
                   ext_power_in, buck_near_in};
  assign pins   = pbseq_in_t'(sync_in);

  pbseq_state_t     state_reg, state_next;
  logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic              tick;
  logic [MS_W-1:0]   press_ms_reg, press_ms_next;
  logic [MS_W-1:0]   state_ms_reg, state_ms_next;
  logic [MS_W-1:0]   good_ms_reg, good_ms_next;
  logic              long_armed_reg, long_armed_next;
  logic              need_release_reg, need_release_next;
  logic              ext_prev_reg, ext_prev_next;
  logic              uv_down_reg, uv_down_next;
  pbseq_out_t        out_reg, out_next;
  logic              press_on, long_press_event, in_down, ext_rise;

  // Slow 1 ms timebase
  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
  assign in_down = (state_reg == ST_HARD_DOWN) ||
                   (state_reg == ST_SOFT_DOWN);
  assign press_on = (press_ms_reg >= PRESS_ON_TICKS) && !need_release_reg;
  assign long_press_event = long_armed_reg &&
                            (press_ms_reg >= LONG_PRESS_TICKS);
  assign ext_rise = pins.ext_power && !ext_prev_reg;

  always_comb begin
    tick_cnt_next     = tick ? '0 : tick_cnt_reg + TICK_W'(1);
    press_ms_next     = press_ms_reg;
    state_ms_next     = state_ms_reg;
    good_ms_next      = good_ms_reg;
    long_armed_next   = long_armed_reg;
    need_release_next = need_release_reg;
    ext_prev_next     = pins.ext_power;
    uv_down_next      = uv_down_reg;
    state_next        = state_reg;
    out_next          = out_reg;

    // Press counter restarts on release
    if (!pins.button_pressed) begin
      press_ms_next     = MS_ZERO;
      need_release_next = 1'b0;
      long_armed_next   = 1'b0;
    end else if (tick && press_ms_reg != {MS_W{1'b1}}) begin
      press_ms_next = press_ms_reg + MS_W'(1);
    end
    // Long press counts only if it started in an up state
    if (pins.button_pressed && press_ms_reg == MS_ZERO &&
        (state_reg == ST_FIRST_POWERUP_STATE || state_reg == ST_SECOND_POWERUP_STATE ||
         state_reg == ST_POWERED))
      long_armed_next = 1'b1;

    if (tick && state_ms_reg != {MS_W{1'b1}})
      state_ms_next = state_ms_reg + MS_W'(1);

    out_next.regs_clear = 1'b0;

    case (state_reg)
      ST_SHIPPING, ST_OFF: begin
        out_next.wake      = 1'b0;
        out_next.buck_en   = 3'b000;
        out_next.good_oe_n = 1'b0;
        uv_down_next       = 1'b0;
        // Retry only after an undervoltage drop; host or reset drop stays off
        if (state_reg == ST_OFF && !pins.undervoltage &&
            state_ms_reg == MS_ZERO && !pins.button_pressed &&
            uv_down_reg) begin
          state_next = ST_SECOND_POWERUP_STATE;
        end else if (press_on || ext_rise ||
                     (pins.hold_power && state_reg == ST_OFF)) begin
          state_next = (state_reg == ST_OFF) ? ST_SECOND_POWERUP_STATE : ST_FIRST_POWERUP_STATE;
        end
        if (state_next != state_reg) begin
          state_ms_next     = MS_ZERO;
          need_release_next = pins.button_pressed;
        end
      end
      ST_FIRST_POWERUP_STATE, ST_SECOND_POWERUP_STATE, ST_POWERED: begin
        out_next.wake       = 1'b1;
        out_next.buck_en[0] = 1'b1;
        if (out_reg.buck_en[0] && pins.buck_near[0])
          out_next.buck_en[1] = 1'b1;
        if (out_reg.buck_en[1] && pins.buck_near[1])
          out_next.buck_en[2] = 1'b1;
        // Good counts 230 ms of third buck in band
        if (!(out_reg.buck_en[2] && pins.buck_near[2]))
          good_ms_next = MS_ZERO;
        else if (tick && good_ms_reg < GOOD_TICKS)
          good_ms_next = good_ms_reg + MS_W'(1);
        if (good_ms_reg >= GOOD_TICKS)
          out_next.good_oe_n = 1'b1;
        if (long_press_event) begin
          state_next = ST_HARD_DOWN;
        end else if (state_reg == ST_POWERED) begin
          if (pins.undervoltage || !pins.hold_power) begin
            state_next   = ST_SOFT_DOWN;
            uv_down_next = pins.undervoltage;
          end
        end else if (state_ms_reg >= POWERUP_TICKS) begin
          state_next = ST_POWERED;
        end
      end
      ST_HARD_DOWN, ST_SOFT_DOWN: begin
        // Regulators stay off through the whole wait
        out_next.wake      = 1'b0;
        out_next.good_oe_n = 1'b0;
        out_next.buck_en   = 3'b000;
        out_next.regs_clear = 1'b1;
        if (state_reg == ST_SOFT_DOWN && long_press_event)
          state_next = ST_HARD_DOWN;
        else if (state_ms_reg >= DOWN_TICKS)
          state_next = (state_reg == ST_HARD_DOWN) ?
                       ST_SHIPPING : ST_OFF;
        if (state_next != state_reg)
          need_release_next = pins.button_pressed;
      end
      default: state_next = ST_SHIPPING;
    endcase

    if (state_next != state_reg) begin
      state_ms_next = MS_ZERO;
      good_ms_next  = MS_ZERO;
      if (state_next == ST_HARD_DOWN || state_next == ST_SOFT_DOWN) begin
        out_next.wake      = 1'b0;
        out_next.good_oe_n = 1'b0;
        out_next.buck_en   = 3'b000;
        long_armed_next    = 1'b0;
      end
    end
    // Down wait leaves no press counted on exit
    if (in_down && state_next == state_reg)
      need_release_next = need_release_reg | pins.button_pressed;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg        <= ST_SOFT_DOWN;
      tick_cnt_reg     <= '0;
      press_ms_reg     <= '0;
      state_ms_reg     <= '0;
      good_ms_reg      <= '0;
      long_armed_reg   <= 1'b0;
      need_release_reg <= 1'b0;
      ext_prev_reg     <= 1'b0;
      uv_down_reg      <= 1'b0;
      // Reset lands in soft down, so serial regs start cleared
      out_reg          <= '{wake: 1'b0, good_oe_n: 1'b0, buck_en: 3'b000,
                            regs_clear: 1'b1};
    end else begin
      state_reg        <= state_next;
      tick_cnt_reg     <= tick_cnt_next;
      press_ms_reg     <= press_ms_next;
      state_ms_reg     <= state_ms_next;
      good_ms_reg      <= good_ms_next;
      long_armed_reg   <= long_armed_next;
      need_release_reg <= need_release_next;
      ext_prev_reg     <= ext_prev_next;
      uv_down_reg      <= uv_down_next;
      out_reg          <= out_next;
    end
  end

  logic [2:0] state_q_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      state_q_reg <= 3'h6;
    else
      state_q_reg <= state_reg;
  end

  assign wake_out          = out_reg.wake;
  assign bucks_good_out_o  = 1'b0;
  assign bucks_good_out_oe = ~out_reg.good_oe_n;
  assign buck_en_out       = out_reg.buck_en;
  assign regs_clear_out    = out_reg.regs_clear;
  assign state_out         = state_q_reg;

endmodule // pbseq_top

// ---- tb/pbseq_buck_model.sv ----
// Partner model: three bucks that report near-regulation after a slew delay
`timescale 1ns/1ps
module pbseq_buck_model #(
  parameter int DLY = 40
) (
  input  wire logic       sys_clk,
  input  wire logic [2:0] buck_en,
  output logic      [2:0] buck_near
);
  int cnt [3];
  initial buck_near = '0;
  // Disabled buck collapses at once, so its near flag drops
  always @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (buck_en[i] !== 1'b1) begin
        cnt[i] <= 0;
        buck_near[i] <= 1'b0;
      end else if (cnt[i] < DLY) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        buck_near[i] <= 1'b1;
      end
    end
  end
endmodule // pbseq_buck_model

// ---- tb/pbseq_chk.sv ----
// Checker: port assertions of the pushbutton power sequencer
`timescale 1ns/1ps
module pbseq_chk (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       button_n,
  input wire logic       hold_power_in,
  input wire logic       output_undervoltage,
  input wire logic       ext_power_in,
  input wire logic [2:0] buck_near_in,
  input wire logic       wake_out,
  input wire logic       bucks_good_out_o,
  input wire logic       bucks_good_out_oe,
  input wire logic [2:0] buck_en_out,
  input wire logic       regs_clear_out,
  input wire logic [2:0] state_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_uv_soft_down: assert property (
    (state_out == 3'h4 && output_undervoltage) [*4] |-> ##[0:4]
    state_out == 3'h6) else $error("undervoltage left powered state late");
  a_soft_outs_off: assert property (
    state_out == 3'h6 && $past(state_out) == 3'h6 |-> !wake_out &&
    bucks_good_out_oe && buck_en_out == 3'h0) else $error("soft down outs");
  a_hard_outs_off: assert property (
    state_out == 3'h5 && $past(state_out) == 3'h5 |-> !wake_out &&
    bucks_good_out_oe && buck_en_out == 3'h0) else $error("hard down outs");
  a_down_clears: assert property (
    state_out inside {3'h5, 3'h6} && $past(state_out) == state_out |->
    regs_clear_out) else $error("down state left serial regs");
  a_soft_to_off: assert property (
    state_out == 3'h6 ##1 state_out != 3'h6 |-> state_out == 3'h1)
    else $error("soft down skipped off state");
  a_hard_to_ship: assert property (
    state_out == 3'h5 ##1 state_out != 3'h5 |-> state_out == 3'h0)
    else $error("hard down did not reach shipping");
  a_wake_buck1: assert property (
    $rose(wake_out) |-> buck_en_out == 3'h1) else $error("wake without buck1");
  a_buck2_order: assert property (
    $rose(buck_en_out[1]) |-> buck_en_out[0] && $past(buck_near_in[0], 2))
    else $error("buck2 enabled early");
  a_buck3_order: assert property (
    $rose(buck_en_out[2]) |-> buck_en_out[1] && $past(buck_near_in[1], 2))
    else $error("buck3 enabled early");
  a_good_release: assert property (
    $fell(bucks_good_out_oe) |-> buck_en_out == 3'h7 && buck_near_in[2])
    else $error("good released before bucks up");
endmodule // pbseq_chk

bind pbseq_top pbseq_chk pbseq_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .button_n(button_n), .hold_power_in(hold_power_in),
  .output_undervoltage(output_undervoltage), .ext_power_in(ext_power_in),
  .buck_near_in(buck_near_in), .wake_out(wake_out),
  .bucks_good_out_o(bucks_good_out_o), .bucks_good_out_oe(bucks_good_out_oe),
  .buck_en_out(buck_en_out), .regs_clear_out(regs_clear_out),
  .state_out(state_out));

// ---- tb/tb_pbseq_top.sv ----
// Testbench: press, undervoltage retry and long-press shipping sequences
`timescale 1ns/1ps
module tb_pbseq_top;
  localparam int TK = 4;
  logic sys_clk = 0, rst_n = 0, button_n = 1, hold_power_in = 0;
  logic output_undervoltage = 0, ext_power_in = 0;
  logic wake_out, good_o, good_oe, regs_clear_out;
  logic [2:0] buck_near_in, buck_en_out, state_out;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  pbseq_top #(.TICK_CYCLES(TK)) pbseq_top_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .button_n(button_n), .hold_power_in(hold_power_in),
    .output_undervoltage(output_undervoltage), .ext_power_in(ext_power_in),
    .buck_near_in(buck_near_in), .wake_out(wake_out),
    .bucks_good_out_o(good_o), .bucks_good_out_oe(good_oe),
    .buck_en_out(buck_en_out), .regs_clear_out(regs_clear_out),
    .state_out(state_out));
  pbseq_buck_model #(.DLY(40)) pbseq_buck_model_inst (.sys_clk(sys_clk),
    .buck_en(buck_en_out), .buck_near(buck_near_in));
  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_val(string what, logic [2:0] exp, logic [2:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ticks(int n);
    repeat (n * TK) @(negedge sys_clk);
  endtask
  task automatic wait_state(logic [2:0] code, int lim);
    for (int i = 0; i < lim * TK && state_out !== code; i++) @(negedge sys_clk);
    check_val("state", code, state_out);
  endtask
  task automatic power_up_press();
    button_n = 0;
    ticks(300);
    button_n = 1;
    ticks(5);
    button_n = 0;
    ticks(395);
    check_val("early press", 3'h1, state_out);
    wait_state(3'h3, 20);
    ticks(1);
    check_val("wake up", 3'h3, {1'b0, wake_out, good_oe});
    button_n = 1;
    hold_power_in = 1;
    for (int i = 0; i < 400 && buck_en_out !== 3'h7; i++) @(negedge sys_clk);
    check_val("bucks", 3'h7, buck_en_out);
    ticks(225);
    check_val("good held", 3'h1, {1'b0, good_o, good_oe});
    ticks(20);
    check_val("good free", 3'h0, {1'b0, good_o, good_oe});
    wait_state(3'h4, 5000);
  endtask
  task automatic uv_recover();
    output_undervoltage = 1;
    wait_state(3'h6, 10);
    ticks(1);
    check_val("soft outs", 3'h3, {wake_out, good_oe, regs_clear_out});
    check_val("soft bucks", 3'h0, buck_en_out);
    output_undervoltage = 0;
    ext_power_in = 1;
    ticks(900);
    check_val("down wait", 3'h6, state_out);
    wait_state(3'h1, 200);
    wait_state(3'h3, 5);
    check_val("regs free", 3'h0, {2'b0, regs_clear_out});
  endtask
  task automatic long_press();
    button_n = 0;
    wait_state(3'h5, 5100);
    ticks(1);
    check_val("hard outs", 3'h3, {wake_out, good_oe, regs_clear_out});
    check_val("hard bucks", 3'h0, buck_en_out);
    wait_state(3'h0, 1100);
    ticks(500);
    check_val("held press", 3'h0, state_out);
    button_n = 1;
    ticks(5);
    button_n = 0;
    wait_state(3'h2, 420);
  endtask
  // Cut a hang short well past the longest expected sequence
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1;
    wait_state(3'h1, 1100);
    power_up_press();
    uv_recover();
    long_press();
    end_of_test();
  end
endmodule // tb_pbseq_top
